// *** pwm_cfg_pkg.sv ***
package pwm_cfg_pkg;
	// register indices on the plain register port
	localparam logic [7:0] ADDR_PERIOD = 8'h00;
	localparam logic [7:0] ADDR_SEVT = 8'h01;
	localparam logic [7:0] ADDR_MDC = 8'h02;
	localparam logic [7:0] ADDR_GLOBAL = 8'h03;
	localparam logic [7:0] GEN_BASE = 8'h10;
	localparam logic [7:0] GEN_STRIDE = 8'h08;
	localparam logic [2:0] GEN_CTRL = 3'h0;
	localparam logic [2:0] GEN_DUTY = 3'h1;
	localparam logic [2:0] GEN_PHASE = 3'h2;
	localparam logic [2:0] GEN_DT = 3'h3;
	localparam logic [2:0] GEN_ALTDT = 3'h4;
	// generator control fields
	localparam int CTL_FLT_PEND = 15;
	localparam int CTL_CL_PEND = 14;
	localparam int CTL_TRG_PEND = 13;
	localparam int CTL_FLT_IEN = 12;
	localparam int CTL_CL_IEN = 11;
	localparam int CTL_TRG_IEN = 10;
	localparam int CTL_ITB = 9;
	localparam int CTL_DUTY_SOURCE_SELECT = 8;
	localparam int CTL_DTC_LO = 6;
	localparam int CTL_EXTERNAL_TIMEBASE_RESET_ENABLE = 1;
	localparam int CTL_IUE = 0;
	localparam logic [15:0] CTRL_WR_MASK = 16'h1FC3;
	// global control fields
	localparam int GL_ENABLE = 0;
	localparam int GL_SE_IEN = 1;
	localparam int GL_SE_PEND = 2;
	localparam logic [15:0] GLOBAL_WR_MASK = 16'h0003;
	// implemented bit masks
	localparam logic [15:0] PERIOD_MASK = 16'hFFF8;
	localparam logic [15:0] SEVT_MASK = 16'hFFF8;
	localparam logic [15:0] PHASE_MASK = 16'hFFFC;
	localparam logic [15:0] ITB_PERIOD_MASK = 16'hFFF0;
	localparam logic [15:0] DT_MASK = 16'h3FFC;
	localparam int DT_LO = 2;
	localparam int DT_HI = 13;
	localparam logic [15:0] RESET_VAL = 16'h0000;
	typedef enum logic [1:0] {
		DT_POS = 2'b00,
		DT_NEG = 2'b01,
		DT_OFF = 2'b10,
		DT_RSVD = 2'b11
	} dt_mode_t;
endpackage

// *** edge_delay.sv ***
`timescale 1ns/1ps
module edge_delay (
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic target_in,
	input wire logic [11:0] delay_in,
	input wire logic delay_rise_in,
	input wire logic delay_fall_in,
	output logic out_out
);
	logic out_q;
	logic out_d;
	logic [11:0] cnt_q;
	logic [11:0] cnt_d;
	logic hold;

	assign out_out = out_q;

	// R11 edge delay
	always_comb begin
		out_d = out_q;
		cnt_d = 12'h000;
		hold = (target_in && delay_rise_in) || (!target_in && delay_fall_in);
		if (target_in != out_q) begin
			if (hold && cnt_q < delay_in) begin
				cnt_d = cnt_q + 12'h001;
			end else begin
				out_d = target_in;
			end
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!resetn_in) begin
			out_q <= 1'b0;
			cnt_q <= 12'h000;
		end else begin
			out_q <= out_d;
			cnt_q <= cnt_d;
		end
	end

	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!resetn_in);

	a_no_delay_follow: assert property ( // R11
		!delay_rise_in && !delay_fall_in && target_in != out_q |=> out_q == $past(target_in))
		else $error("edge passed late with dead time disabled");
	a_rise_held: assert property ( // R11
		delay_rise_in && !out_q && target_in && delay_in != 12'h000 && cnt_q == 12'h000
		|=> !out_q)
		else $error("rising edge not delayed");
endmodule // edge_delay

// *** gen_core.sv ***
`timescale 1ns/1ps
module gen_core (
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic enable_in,
	input wire logic prim_wrap_in,
	input wire logic [15:0] prim_period_in,
	input wire logic itb_in,
	input wire logic [15:0] phase_in,
	input wire logic ext_reset_in,
	input wire logic [15:0] duty_sel_in,
	input wire logic iue_in,
	output logic raw_out
);
	logic [15:0] cnt_q;
	logic [15:0] cnt_d;
	logic [15:0] duty_act_q;
	logic [15:0] duty_act_d;
	logic raw_q;
	logic raw_d;
	logic start;
	logic [15:0] itb_period;

	assign raw_out = raw_q;

	always_comb begin
		itb_period = phase_in & pwm_cfg_pkg::ITB_PERIOD_MASK;
		start = 1'b0;
		cnt_d = cnt_q + 16'h0001;
		if (!enable_in) begin
			cnt_d = 16'h0000;
		end else if (itb_in) begin
			// R12 current-limit restart
			// R9 own period from phase
			if (ext_reset_in || cnt_q >= itb_period) begin
				cnt_d = 16'h0000;
				start = 1'b1;
			end
		end else if (prim_wrap_in) begin
			// R14 phase offset
			cnt_d = phase_in & pwm_cfg_pkg::PHASE_MASK;
			start = 1'b1;
		end else if (cnt_q >= prim_period_in) begin
			cnt_d = 16'h0000;
		end
		// R13 immediate or period-synced
		duty_act_d = (iue_in || start) ? duty_sel_in : duty_act_q;
		// R20 compare against duty
		raw_d = enable_in && (cnt_q < duty_act_q);
	end

	always_ff @(posedge clk_sys_in) begin
		if (!resetn_in) begin
			cnt_q <= 16'h0000;
			duty_act_q <= pwm_cfg_pkg::RESET_VAL;
			raw_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			duty_act_q <= duty_act_d;
			raw_q <= raw_d;
		end
	end

	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!resetn_in);

	a_ext_restart: assert property ( // R12
		enable_in && itb_in && ext_reset_in |=> cnt_q == 16'h0000)
		else $error("external reset did not restart time base");
	a_itb_wrap: assert property ( // R9
		enable_in && itb_in && cnt_q >= itb_period |=> cnt_q == 16'h0000)
		else $error("independent period did not wrap");
	a_iue_now: assert property ( // R13
		iue_in |=> duty_act_q == $past(duty_sel_in))
		else $error("immediate duty update late");
	a_sync_hold: assert property ( // R13
		!iue_in && !start |=> duty_act_q == $past(duty_act_q))
		else $error("duty changed outside period start");
	a_out_active: assert property ( // R20
		enable_in && cnt_q < duty_act_q |=> raw_q)
		else $error("output inactive below duty");
endmodule // gen_core

// *** pwm_config_top.sv ***
`timescale 1ns/1ps
// Functional notes
// R1 - special event compare keeps bits 15-3; bits 2-0 read zero
// R2 - software keeps master duty within 0x0008 to 0xFFEF
// R3 - software keeps each generator duty within 0x0008 to 0xFFEF
// R4 - fault pending set by hardware; clearing fault enable clears it
// R5 - current-limit pending set by hardware; clearing its enable clears it
// R6 - with trigger enable set, trigger sets pending and requests interrupt
// R7 - clearing trigger enable disables it and clears trigger pending
// R8 - software acknowledges by clearing pending and interrupt controller flag
// R9 - independent select 0 uses primary base; 1 uses phase as period
// R10 - duty source 0 own duty register; 1 shared master duty
// R11 - dead-time mode 00 positive, 01 negative, 10 off, 11 reserved
// R12 - external reset bit lets current limit restart independent time base
// R13 - immediate bit applies duty at once, else at period start
// R14 - phase holds bits 15-2; bits 3-2 ignored as independent period
// R15 - dead time holds bits 13-2; other bits read zero
// R16 - alternate dead time holds bits 13-2; other bits read zero
// R17 - primary period holds bits 15-3; bits 2-0 read zero
// R18 - compare match sets special event pending; irq only when enabled
// R19 - counter equal to compare gives one-cycle special event pulse
// R20 - output active while count below selected duty, before dead time
module pwm_config_top #(
	parameter int NUM_GEN = 4
) (
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic [7:0] addr_in,
	input wire logic [15:0] wr_data_in,
	input wire logic wr_en_in,
	input wire logic rd_en_in,
	output logic [15:0] rd_data_out,
	input wire logic [NUM_GEN-1:0] fault_in,
	input wire logic [NUM_GEN-1:0] current_limit_in,
	input wire logic [NUM_GEN-1:0] trigger_in,
	output logic [NUM_GEN-1:0] pwm_h_out,
	output logic [NUM_GEN-1:0] pwm_l_out,
	output logic [NUM_GEN-1:0] fault_irq_out,
	output logic [NUM_GEN-1:0] current_limit_irq_out,
	output logic [NUM_GEN-1:0] trigger_irq_out,
	output logic special_event_irq_out,
	output logic special_event_out
);
	if (NUM_GEN < 1 || NUM_GEN > 8) begin : g_check
		$error("NUM_GEN must be 1 to 8");
	end

	function automatic logic gen_hit(input logic [7:0] a, input int g, input logic [2:0] sub);
		int target;
		target = int'(pwm_cfg_pkg::GEN_BASE) + g * int'(pwm_cfg_pkg::GEN_STRIDE) + int'(sub);
		return a == target[7:0];
	endfunction

	// register state
	logic [15:0] period_q, period_d;
	logic [15:0] sevt_q, sevt_d;
	logic [15:0] mdc_q, mdc_d;
	logic [15:0] glob_q, glob_d;
	logic se_pend_q, se_pend_d;
	logic [15:0] ctrl_q [NUM_GEN], ctrl_d [NUM_GEN];
	logic [15:0] duty_q [NUM_GEN], duty_d [NUM_GEN];
	logic [15:0] phase_q [NUM_GEN], phase_d [NUM_GEN];
	logic [15:0] dt_q [NUM_GEN], dt_d [NUM_GEN];
	logic [15:0] altdt_q [NUM_GEN], altdt_d [NUM_GEN];
	logic [NUM_GEN-1:0] flt_pend_q, flt_pend_d;
	logic [NUM_GEN-1:0] cl_pend_q, cl_pend_d;
	logic [NUM_GEN-1:0] trg_pend_q, trg_pend_d;
	logic [15:0] rd_data_q, rd_data_d;
	// time base state is declared here, the pending logic below reads the match
	logic enable, prim_wrap, se_hit;
	logic [15:0] primary_timebase_counter_q, primary_timebase_counter_d;
	logic se_pulse_q, se_pulse_d;

	always_comb begin
		period_d = period_q;
		sevt_d = sevt_q;
		mdc_d = mdc_q;
		glob_d = glob_q;
		se_pend_d = se_pend_q;
		if (wr_en_in) begin
			unique case (addr_in)
				// R17 period field
				pwm_cfg_pkg::ADDR_PERIOD: period_d = wr_data_in & pwm_cfg_pkg::PERIOD_MASK;
				// R1 compare field
				pwm_cfg_pkg::ADDR_SEVT: sevt_d = wr_data_in & pwm_cfg_pkg::SEVT_MASK;
				pwm_cfg_pkg::ADDR_MDC: mdc_d = wr_data_in;
				pwm_cfg_pkg::ADDR_GLOBAL: begin
					glob_d = wr_data_in & pwm_cfg_pkg::GLOBAL_WR_MASK;
					if (!wr_data_in[pwm_cfg_pkg::GL_SE_PEND]) begin
						se_pend_d = 1'b0;
					end
				end
				default: ;
			endcase
		end
		// R18 match sets pending, set wins
		if (se_hit) begin
			se_pend_d = 1'b1;
		end
	end

	always_comb begin
		for (int g = 0; g < NUM_GEN; g++) begin
			ctrl_d[g] = ctrl_q[g];
			duty_d[g] = duty_q[g];
			phase_d[g] = phase_q[g];
			dt_d[g] = dt_q[g];
			altdt_d[g] = altdt_q[g];
			if (wr_en_in && gen_hit(addr_in, g, pwm_cfg_pkg::GEN_CTRL)) begin
				ctrl_d[g] = wr_data_in & pwm_cfg_pkg::CTRL_WR_MASK;
			end
			if (wr_en_in && gen_hit(addr_in, g, pwm_cfg_pkg::GEN_DUTY)) begin
				duty_d[g] = wr_data_in;
			end
			// R14 phase field
			if (wr_en_in && gen_hit(addr_in, g, pwm_cfg_pkg::GEN_PHASE)) begin
				phase_d[g] = wr_data_in & pwm_cfg_pkg::PHASE_MASK;
			end
			// R15 dead time field
			if (wr_en_in && gen_hit(addr_in, g, pwm_cfg_pkg::GEN_DT)) begin
				dt_d[g] = wr_data_in & pwm_cfg_pkg::DT_MASK;
			end
			// R16 alternate dead time field
			if (wr_en_in && gen_hit(addr_in, g, pwm_cfg_pkg::GEN_ALTDT)) begin
				altdt_d[g] = wr_data_in & pwm_cfg_pkg::DT_MASK;
			end
			// R4 fault pending
			flt_pend_d[g] = (flt_pend_q[g] | fault_in[g]) & ctrl_d[g][pwm_cfg_pkg::CTL_FLT_IEN];
			// R5 current-limit pending
			cl_pend_d[g] = (cl_pend_q[g] | current_limit_in[g])
				& ctrl_d[g][pwm_cfg_pkg::CTL_CL_IEN];
			// R6 R7 trigger pending
			trg_pend_d[g] = (trg_pend_q[g] | trigger_in[g]) & ctrl_d[g][pwm_cfg_pkg::CTL_TRG_IEN];
		end
	end

	// register read-back, one cycle after the strobe
	always_comb begin
		rd_data_d = 16'h0000;
		if (rd_en_in) begin
			unique case (addr_in)
				pwm_cfg_pkg::ADDR_PERIOD: rd_data_d = period_q;
				pwm_cfg_pkg::ADDR_SEVT: rd_data_d = sevt_q;
				pwm_cfg_pkg::ADDR_MDC: rd_data_d = mdc_q;
				pwm_cfg_pkg::ADDR_GLOBAL: begin
					rd_data_d = glob_q;
					rd_data_d[pwm_cfg_pkg::GL_SE_PEND] = se_pend_q;
				end
				default: ;
			endcase
			for (int g = 0; g < NUM_GEN; g++) begin
				if (gen_hit(addr_in, g, pwm_cfg_pkg::GEN_CTRL)) begin
					rd_data_d = ctrl_q[g];
					rd_data_d[pwm_cfg_pkg::CTL_FLT_PEND] = flt_pend_q[g];
					rd_data_d[pwm_cfg_pkg::CTL_CL_PEND] = cl_pend_q[g];
					rd_data_d[pwm_cfg_pkg::CTL_TRG_PEND] = trg_pend_q[g];
				end
				if (gen_hit(addr_in, g, pwm_cfg_pkg::GEN_DUTY)) begin
					rd_data_d = duty_q[g];
				end
				if (gen_hit(addr_in, g, pwm_cfg_pkg::GEN_PHASE)) begin
					rd_data_d = phase_q[g];
				end
				if (gen_hit(addr_in, g, pwm_cfg_pkg::GEN_DT)) begin
					rd_data_d = dt_q[g];
				end
				if (gen_hit(addr_in, g, pwm_cfg_pkg::GEN_ALTDT)) begin
					rd_data_d = altdt_q[g];
				end
			end
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!resetn_in) begin
			period_q <= pwm_cfg_pkg::RESET_VAL;
			sevt_q <= pwm_cfg_pkg::RESET_VAL;
			mdc_q <= pwm_cfg_pkg::RESET_VAL;
			glob_q <= pwm_cfg_pkg::RESET_VAL;
			se_pend_q <= 1'b0;
			flt_pend_q <= '0;
			cl_pend_q <= '0;
			trg_pend_q <= '0;
			rd_data_q <= 16'h0000;
			for (int g = 0; g < NUM_GEN; g++) begin
				ctrl_q[g] <= pwm_cfg_pkg::RESET_VAL;
				duty_q[g] <= pwm_cfg_pkg::RESET_VAL;
				phase_q[g] <= pwm_cfg_pkg::RESET_VAL;
				dt_q[g] <= pwm_cfg_pkg::RESET_VAL;
				altdt_q[g] <= pwm_cfg_pkg::RESET_VAL;
			end
		end else begin
			period_q <= period_d;
			sevt_q <= sevt_d;
			mdc_q <= mdc_d;
			glob_q <= glob_d;
			se_pend_q <= se_pend_d;
			flt_pend_q <= flt_pend_d;
			cl_pend_q <= cl_pend_d;
			trg_pend_q <= trg_pend_d;
			rd_data_q <= rd_data_d;
			for (int g = 0; g < NUM_GEN; g++) begin
				ctrl_q[g] <= ctrl_d[g];
				duty_q[g] <= duty_d[g];
				phase_q[g] <= phase_d[g];
				dt_q[g] <= dt_d[g];
				altdt_q[g] <= altdt_d[g];
			end
		end
	end

	assign rd_data_out = rd_data_q;
	assign fault_irq_out = flt_pend_q;
	assign current_limit_irq_out = cl_pend_q;
	assign trigger_irq_out = trg_pend_q;

	// primary time base and special event
	always_comb begin
		enable = glob_q[pwm_cfg_pkg::GL_ENABLE];
		prim_wrap = enable && (primary_timebase_counter_q >= period_q);
		primary_timebase_counter_d = prim_wrap ? 16'h0000 : primary_timebase_counter_q + 16'h0001;
		if (!enable) begin
			primary_timebase_counter_d = 16'h0000;
		end
		// R19 compare match
		se_hit = enable && (primary_timebase_counter_q == sevt_q);
		se_pulse_d = se_hit;
	end

	always_ff @(posedge clk_sys_in) begin
		if (!resetn_in) begin
			primary_timebase_counter_q <= 16'h0000;
			se_pulse_q <= 1'b0;
		end else begin
			primary_timebase_counter_q <= primary_timebase_counter_d;
			se_pulse_q <= se_pulse_d;
		end
	end

	assign special_event_out = se_pulse_q;
	// R18 irq gated by enable
	assign special_event_irq_out = se_pend_q && glob_q[pwm_cfg_pkg::GL_SE_IEN];

	// per-generator datapath
	for (genvar g = 0; g < NUM_GEN; g++) begin : g_gen
		logic [15:0] duty_sel;
		logic raw;
		logic ext_reset;
		logic rise_dly;
		logic fall_dly;
		pwm_cfg_pkg::dt_mode_t mode;

		// R10 duty source
		assign duty_sel = ctrl_q[g][pwm_cfg_pkg::CTL_DUTY_SOURCE_SELECT] ? mdc_q : duty_q[g];
		// R12 current-limit reset path
		assign ext_reset = ctrl_q[g][pwm_cfg_pkg::CTL_EXTERNAL_TIMEBASE_RESET_ENABLE] && current_limit_in[g];
		assign mode = pwm_cfg_pkg::dt_mode_t'(
			ctrl_q[g][pwm_cfg_pkg::CTL_DTC_LO+1:pwm_cfg_pkg::CTL_DTC_LO]);
		// R11 mode decode
		assign rise_dly = (mode == pwm_cfg_pkg::DT_POS);
		assign fall_dly = (mode == pwm_cfg_pkg::DT_NEG);

		gen_core u_core (
			.clk_sys_in(clk_sys_in),
			.resetn_in(resetn_in),
			.enable_in(enable),
			.prim_wrap_in(prim_wrap),
			.prim_period_in(period_q),
			.itb_in(ctrl_q[g][pwm_cfg_pkg::CTL_ITB]),
			.phase_in(phase_q[g]),
			.ext_reset_in(ext_reset),
			.duty_sel_in(duty_sel),
			.iue_in(ctrl_q[g][pwm_cfg_pkg::CTL_IUE]),
			.raw_out(raw)
		);

		edge_delay u_dly_h (
			.clk_sys_in(clk_sys_in),
			.resetn_in(resetn_in),
			.target_in(raw),
			.delay_in(dt_q[g][pwm_cfg_pkg::DT_HI:pwm_cfg_pkg::DT_LO]),
			.delay_rise_in(rise_dly),
			.delay_fall_in(fall_dly),
			.out_out(pwm_h_out[g])
		);

		edge_delay u_dly_l (
			.clk_sys_in(clk_sys_in),
			.resetn_in(resetn_in),
			.target_in(!raw),
			.delay_in(altdt_q[g][pwm_cfg_pkg::DT_HI:pwm_cfg_pkg::DT_LO]),
			.delay_rise_in(rise_dly),
			.delay_fall_in(fall_dly),
			.out_out(pwm_l_out[g])
		);
	end

	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!resetn_in);

	a_sevt_low_zero: assert property ( // R1
		rd_en_in && addr_in == pwm_cfg_pkg::ADDR_SEVT |=> rd_data_out[2:0] == 3'h0)
		else $error("compare low bits not zero");
	a_period_low_zero: assert property ( // R17
		rd_en_in && addr_in == pwm_cfg_pkg::ADDR_PERIOD |=> rd_data_out[2:0] == 3'h0)
		else $error("period low bits not zero");
	a_dt_unimpl_zero: assert property ( // R15
		rd_en_in && addr_in == 8'h13 |=> rd_data_out[15:14] == 2'h0 && rd_data_out[1:0] == 2'h0)
		else $error("dead time unimplemented bits set");
	a_altdt_unimpl_zero: assert property ( // R16
		rd_en_in && addr_in == 8'h14 |=> rd_data_out[15:14] == 2'h0 && rd_data_out[1:0] == 2'h0)
		else $error("alternate dead time unimplemented bits set");
	a_fault_clear: assert property ( // R4
		wr_en_in && addr_in == 8'h10 && !wr_data_in[12]
		|=> !fault_irq_out[0] ##1 (!fault_irq_out[0] || fault_in[0]))
		else $error("fault pending not cleared");
	a_cl_clear: assert property ( // R5
		wr_en_in && addr_in == 8'h10 && !wr_data_in[11] |=> !current_limit_irq_out[0])
		else $error("current-limit pending not cleared");
	a_trg_set: assert property ( // R6
		trigger_in[0] && ctrl_d[0][10] |=> trigger_irq_out[0] && trg_pend_q[0])
		else $error("trigger event lost");
	a_trg_clear: assert property ( // R7
		wr_en_in && addr_in == 8'h10 && !wr_data_in[10] |=> !trigger_irq_out[0])
		else $error("trigger pending not cleared");
	a_sevt_pulse: assert property ( // R19
		se_hit |=> special_event_out && se_pend_q)
		else $error("special event pulse missing");
	a_se_irq_gate: assert property ( // R18
		$rose(se_pend_q) && !glob_q[1] |-> !special_event_irq_out)
		else $error("special event irq while disabled");
	a_duty_source: assert property ( // R10
		ctrl_q[0][8] |-> g_gen[0].duty_sel == mdc_q)
		else $error("master duty not selected");
endmodule // pwm_config_top

// *** converter_model.sv ***
`timescale 1ns/1ps
module converter_model #(
	parameter int NUM_GEN = 2
) (
	input wire logic clk_sys_in,
	input wire logic slow_in,
	input wire logic [NUM_GEN-1:0] pwm_h_in,
	input wire logic [NUM_GEN-1:0] pwm_l_in,
	input wire logic [NUM_GEN-1:0] fault_req_in,
	input wire logic [NUM_GEN-1:0] cl_req_in,
	input wire logic [NUM_GEN-1:0] trg_req_in,
	output logic [NUM_GEN-1:0] fault_out,
	output logic [NUM_GEN-1:0] current_limit_out,
	output logic [NUM_GEN-1:0] trigger_out,
	output logic [NUM_GEN-1:0] shoot_through_out
);
	// comparator sensing chain; slow_in adds two cycles of sensing delay
	logic [3*NUM_GEN-1:0] stage_a_q = '0;
	logic [3*NUM_GEN-1:0] stage_b_q = '0;
	logic [3*NUM_GEN-1:0] stage_c_q = '0;
	always_ff @(posedge clk_sys_in) begin
		stage_a_q <= {trg_req_in, cl_req_in, fault_req_in};
		stage_b_q <= stage_a_q;
		stage_c_q <= stage_b_q;
	end
	assign {trigger_out, current_limit_out, fault_out} = slow_in ? stage_c_q : stage_a_q;
	// both switches of a leg on at once shorts the supply
	assign shoot_through_out = pwm_h_in & pwm_l_in;
endmodule // converter_model

// *** smps_pwm_generator_config_test.sv ***
`timescale 1ns/1ps
module smps_pwm_generator_config_test;
	logic clk_sys_in = 1'b0;
	logic resetn_in = 1'b0;
	logic [7:0] addr_in = 8'h00;
	logic [15:0] wr_data_in = 16'h0000;
	logic wr_en_in = 1'b0;
	logic rd_en_in = 1'b0;
	logic slow = 1'b0;
	logic [1:0] f_req = 2'h0;
	logic [1:0] c_req = 2'h0;
	logic [1:0] t_req = 2'h0;
	logic [15:0] rd_data_out;
	logic [1:0] fault, cl, trg, pwm_h_out, pwm_l_out, shoot;
	logic [1:0] fault_irq, cl_irq, trg_irq;
	logic special_event_irq_out, special_event_out;
	int fail_count = 0;
	int total_checks = 0;

	pwm_config_top #(.NUM_GEN(2)) pwm_config_top_inst (.clk_sys_in(clk_sys_in),
		.resetn_in(resetn_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
		.wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .rd_data_out(rd_data_out),
		.fault_in(fault), .current_limit_in(cl), .trigger_in(trg),
		.pwm_h_out(pwm_h_out), .pwm_l_out(pwm_l_out), .fault_irq_out(fault_irq),
		.current_limit_irq_out(cl_irq), .trigger_irq_out(trg_irq),
		.special_event_irq_out(special_event_irq_out),
		.special_event_out(special_event_out));
	converter_model #(.NUM_GEN(2)) converter_model_inst (.clk_sys_in(clk_sys_in),
		.slow_in(slow), .pwm_h_in(pwm_h_out), .pwm_l_in(pwm_l_out),
		.fault_req_in(f_req), .cl_req_in(c_req), .trg_req_in(t_req),
		.fault_out(fault), .current_limit_out(cl), .trigger_out(trg),
		.shoot_through_out(shoot));

	always #50 clk_sys_in = ~clk_sys_in;

	task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	function automatic logic [7:0] ga(input int g, input logic [2:0] off);
		return pwm_cfg_pkg::GEN_BASE + pwm_cfg_pkg::GEN_STRIDE * 8'(g) + {5'h00, off};
	endfunction

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_sys_in);
		addr_in <= a;
		wr_data_in <= d;
		wr_en_in <= 1'b1;
		@(posedge clk_sys_in);
		wr_en_in <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk_sys_in);
		addr_in <= a;
		rd_en_in <= 1'b1;
		@(posedge clk_sys_in);
		rd_en_in <= 1'b0;
		#1;
		d = rd_data_out;
	endtask

	task automatic pulse(input int k, input int g);
		@(posedge clk_sys_in);
		if (k == 0) f_req[g] <= 1'b1;
		else if (k == 1) c_req[g] <= 1'b1;
		else t_req[g] <= 1'b1;
		@(posedge clk_sys_in);
		f_req <= 2'h0;
		c_req <= 2'h0;
		t_req <= 2'h0;
	endtask

	task automatic settle();
		repeat (140) @(posedge clk_sys_in);
	endtask

	// one full primary period of generator 0
	task automatic measure(output int nh, output int nl, output int nov);
		nh = 0;
		nl = 0;
		nov = 0;
		repeat (65) begin
			@(negedge clk_sys_in);
			nh += int'(pwm_h_out[0]);
			nl += int'(pwm_l_out[0]);
			nov += int'(shoot[0]);
		end
	endtask

	task automatic wait_rise(output int n);
		n = 0;
		while (pwm_h_out[0] === 1'b1 && n < 300) begin
			@(negedge clk_sys_in);
			n++;
		end
		while (pwm_h_out[0] !== 1'b1 && n < 300) begin
			@(negedge clk_sys_in);
			n++;
		end
	endtask

	task automatic count_high(output int n);
		n = 0;
		repeat (6) begin
			@(negedge clk_sys_in);
			n += int'(pwm_h_out[0]);
		end
	endtask

	task automatic wait_se();
		int n;
		n = 0;
		while (special_event_out !== 1'b1 && n < 200) begin
			@(negedge clk_sys_in);
			n++;
		end
		chk("event pulse", 16'(n < 200), 16'h0001);
		@(negedge clk_sys_in);
		chk("pulse width", 16'(special_event_out), 16'h0000);
	endtask

	task automatic t_regs();
		logic [7:0] ra [9];
		logic [15:0] wd [9];
		logic [15:0] m [9];
		logic [15:0] d;
		ra = '{8'h00, 8'h01, 8'h02, ga(0, 3'h0), ga(0, 3'h1), ga(0, 3'h2), ga(0, 3'h3),
			ga(0, 3'h4), 8'h05};
		wd = '{16'hFFFF, 16'hFFFF, 16'hFFEF, 16'hFFFF, 16'hFFEF, 16'hFFFF, 16'hFFFF,
			16'hFFFF, 16'hFFFF};
		m = '{16'hFFF8, 16'hFFF8, 16'hFFFF, 16'h1FC3, 16'hFFFF, 16'hFFFC, 16'h3FFC,
			16'h3FFC, 16'h0000};
		for (int i = 0; i < 9; i++) begin
			rd(ra[i], d);
			chk("reset value", d, 16'h0000);
			wr(ra[i], wd[i]);
			rd(ra[i], d);
			chk("readback", d, wd[i] & m[i]);
			wr(ra[i], 16'h0000);
		end
		$display("test registers done");
	endtask

	task automatic t_event(input int k, input logic s);
		logic [15:0] d;
		logic [7:0] a;
		a = ga(0, 3'h0);
		slow <= s;
		wr(a, 16'h0001 << (12 - k));
		pulse(k, 0);
		repeat (5) @(posedge clk_sys_in);
		#1;
		chk("irq raised", 16'({trg_irq[0], cl_irq[0], fault_irq[0]} >> k), 16'h0001);
		rd(a, d);
		chk("pending set", d, (16'h0001 << (12 - k)) | (16'h0001 << (15 - k)));
		wr(a, 16'h0000);
		rd(a, d);
		chk("pending cleared", d, 16'h0000);
		pulse(k, 0);
		repeat (5) @(posedge clk_sys_in);
		#1;
		chk("irq disabled", 16'({trg_irq[0], cl_irq[0], fault_irq[0]} >> k), 16'h0000);
		slow <= 1'b0;
		$display("test event %0d done", k);
	endtask

	task automatic t_special();
		logic [15:0] d;
		wr(8'h00, 16'h0040);
		wr(8'h01, 16'h0020);
		wr(8'h03, 16'h0003);
		wait_se();
		chk("se irq", 16'(special_event_irq_out), 16'h0001);
		rd(8'h03, d);
		chk("se pending", d, 16'h0007);
		wr(8'h03, 16'h0001);
		rd(8'h03, d);
		chk("se cleared", d, 16'h0001);
		wait_se();
		chk("se irq masked", 16'(special_event_irq_out), 16'h0000);
		rd(8'h03, d);
		chk("se pend masked", d, 16'h0005);
		$display("test special event done");
	endtask

	task automatic t_duty();
		int nh, nl, nov;
		wr(ga(0, 3'h1), 16'h0020);
		wr(ga(0, 3'h0), 16'h0080);
		settle();
		measure(nh, nl, nov);
		chk("own duty high", 16'(nh), 16'd32);
		chk("own duty low", 16'(nl), 16'd33);
		wr(8'h02, 16'h0010);
		wr(ga(0, 3'h0), 16'h0180);
		settle();
		measure(nh, nl, nov);
		chk("master duty", 16'(nh), 16'd16);
		$display("test duty done");
	endtask

	task automatic t_update(input logic immediate_duty_update);
		int n;
		wr(ga(0, 3'h0), {15'h0040, immediate_duty_update});
		wr(ga(0, 3'h1), 16'h0020);
		settle();
		wait_rise(n);
		repeat (38) @(posedge clk_sys_in);
		wr(ga(0, 3'h1), 16'h0030);
		count_high(n);
		chk("update timing", 16'(n != 0), 16'(immediate_duty_update));
		$display("test update %0d done", immediate_duty_update);
	endtask

	task automatic t_itb();
		int n;
		wr(ga(0, 3'h2), 16'h0034);
		wr(ga(0, 3'h1), 16'h0010);
		wr(ga(0, 3'h0), 16'h0280);
		settle();
		wait_rise(n);
		wait_rise(n);
		chk("own period", 16'(n), 16'd49);
		for (int x = 1; x >= 0; x--) begin
			wr(ga(0, 3'h0), 16'h0280 | (16'(x) << 1));
			wait_rise(n);
			repeat (25) @(posedge clk_sys_in);
			pulse(1, 0);
			count_high(n);
			chk("external restart", 16'(n != 0), 16'(x));
		end
		wr(ga(0, 3'h0), 16'h0080);
		$display("test time base done");
	endtask

	task automatic t_dead();
		int nh, nl, nov;
		wr(ga(0, 3'h1), 16'h0020);
		wr(ga(0, 3'h3), 16'h0010);
		wr(ga(0, 3'h4), 16'h0010);
		for (int md = 0; md < 4; md++) begin
			wr(ga(0, 3'h0), 16'(md) << 6);
			settle();
			measure(nh, nl, nov);
			if (md == 0) begin
				chk("no overlap", 16'(nov), 16'h0000);
				chk("positive", 16'(nh < 32), 16'h0001);
			end else if (md == 1) begin
				chk("negative", 16'(nh > 32), 16'h0001);
			end else begin
				chk("dead off", 16'(nh), 16'd32);
			end
		end
		$display("test dead time done");
	endtask

	initial begin
		repeat (16) @(posedge clk_sys_in);
		resetn_in <= 1'b1;
		@(posedge clk_sys_in);
		t_regs();
		for (int k = 0; k < 3; k++) begin
			t_event(k, k == 1);
		end
		t_special();
		t_duty();
		t_update(1'b0);
		t_update(1'b1);
		t_itb();
		t_dead();
		tally_and_finish();
	end

	initial begin
		#3000000;
		fail_count++;
		tally_and_finish();
	end
endmodule // smps_pwm_generator_config_test
